// ==== logic/asp_pkg.sv ====
// Constants and types for the converter serial port block
// Overview of operation
// - Filter-align low holds filter, calibration control and modulator in reset.
// - Filter-align never disturbs the serial host port; register access continues.
// - Filter-align forces a pending ready indication back high.
// - Shared output goes low when a conversion completes.
// - Unread result: ready returns high before the next result update.
// - Output shift register loads from any data or control register.
// - Output changes on falling serial clock, host samples on rising edge.
// - Input bits collect in a shift register, then write the selected register.
// - Continuous or burst serial clocks both assemble words correctly.
// - Serial port answers only while chip select is low.
// - Chip select tied low gives three-wire operation.
// - Internal 4.92 MHz master clock, optionally driven out on the clock pin.
package asp_pkg;

  localparam int REG_W = 24;
  localparam int CMD_W = 8;
  localparam int SEL_W = 3;
  localparam int CNT_W = 5;
  localparam int NUM_REGS = 8;

  // Command byte layout
  localparam int CMD_RD_BIT = 6;
  localparam int CMD_SEL_LSB = 3;

  // Register selects
  localparam logic [SEL_W-1:0] SEL_STATUS = 3'h0;
  localparam logic [SEL_W-1:0] SEL_MODE = 3'h1;
  localparam logic [SEL_W-1:0] SEL_DATA = 3'h3;
  localparam int MODE_CLKOUT_BIT = 0;

  // Input sampler bit positions and reset levels (idle high clock, pulled-up align)
  localparam int IN_N = 4;
  localparam int IN_SCLK = 0;
  localparam int IN_CS = 1;
  localparam int IN_DIN = 2;
  localparam int IN_ALIGN = 3;
  localparam logic [IN_N-1:0] IN_RST = 4'hB;

  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYS_CLK_KHZ = 25000;
  localparam int INT_MCLK_KHZ = 4920;
  localparam int ACC_W = 16;
  localparam logic [ACC_W-1:0] ACC_INC =
    ACC_W'((longint'(INT_MCLK_KHZ) << ACC_W) / SYS_CLK_KHZ);
  localparam int RDY_GAP_NS = 200;
  localparam int RDY_GAP_CYC_I = (RDY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] RDY_GAP_CYC = 4'(RDY_GAP_CYC_I);

  // Reset values
  localparam logic [REG_W-1:0] REG_RST = 24'h00_0000;
  localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
  localparam logic [ACC_W-1:0] ACC_RST = 16'h0000;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } asp_pins_s;

  typedef enum logic [1:0] {
    ST_COMM = 2'h0,
    ST_WR = 2'h1,
    ST_RD = 2'h2
  } asp_state_e;

endpackage

// ==== logic/asp_reg_mem.sv ====
// Control register storage with registered read data
`timescale 1ns/1ns
module asp_reg_mem import asp_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [SEL_W-1:0] waddr_i,
  input wire logic [REG_W-1:0] wdata_i,
  // Read port
  input wire logic [SEL_W-1:0] raddr_i,
  output logic [REG_W-1:0] rdata_o
);

  logic [REG_W-1:0] mem_reg [NUM_REGS];

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        mem_reg[i] <= REG_RST;
      end
      rdata_o <= REG_RST;
    end else begin
      if (we_i) begin
        mem_reg[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_reg[raddr_i];
    end
  end

endmodule

// ==== logic/asp_serial_port.sv ====
// Serial host port, filter alignment and conversion-ready signalling
`timescale 1ns/1ns
module asp_serial_port import asp_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Host serial pins
  input wire asp_pins_s host_i,
  output logic serial_out_done_n_o,
  output logic serial_out_done_oe_o,
  // Filter alignment pin
  input wire logic filter_align_n_i,
  // Converter side
  input wire logic conv_done_i,
  input wire logic [REG_W-1:0] conv_data_i,
  output logic filter_rst_o,
  output logic cal_rst_o,
  output logic mod_rst_o,
  // Master clock pin
  output logic master_clock_pin_o,
  output logic master_clock_pin_oe_o
);

  // Input samplers: three stages, change accepted when stages two and three agree
  logic [IN_N-1:0] raw;
  logic [IN_N-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
  logic [IN_N-1:0] s1_next, s2_next, s3_next;
  // Reset levels equal the idle pin levels, so no false edge follows reset

  assign raw = {filter_align_n_i, host_i.din, host_i.cs_n, host_i.sclk};

  function automatic logic settle(input logic a, input logic b, input logic cur);
    return (a == b) ? b : cur;
  endfunction

  function automatic logic word_end(input logic [CNT_W-1:0] cnt);
    return cnt == CNT_W'(REG_W - 1);
  endfunction

  // Status word: ready flag, alignment flag, rest zero
  function automatic logic [REG_W-1:0] status_word(input logic rdy_n, input logic align);
    return {rdy_n, align, {(REG_W-2){1'b0}}};
  endfunction

  always_comb begin
    s1_next = raw;
    s2_next = s1_reg;
    s3_next = s2_reg;
    for (int i = 0; i < IN_N; i++) begin
      lvl_next[i] = settle(s2_reg[i], s3_reg[i], lvl_reg[i]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s1_reg <= IN_RST;
      s2_reg <= IN_RST;
      s3_reg <= IN_RST;
      lvl_reg <= IN_RST;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  logic sclk_rise, sclk_fall, cs_act, din_s, align_act;

  assign sclk_rise = lvl_next[IN_SCLK] & ~lvl_reg[IN_SCLK];
  assign sclk_fall = ~lvl_next[IN_SCLK] & lvl_reg[IN_SCLK];
  assign cs_act = ~lvl_reg[IN_CS];
  assign din_s = lvl_reg[IN_DIN];
  assign align_act = ~lvl_reg[IN_ALIGN];

  // Serial protocol state
  asp_state_e st_reg, st_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [REG_W-1:0] in_sh_reg, in_sh_next;
  logic [REG_W-1:0] out_sh_reg, out_sh_next;
  logic [SEL_W-1:0] sel_reg, sel_next;
  logic load_reg, load_next;
  logic dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic clkout_en_reg, clkout_en_next;
  logic mem_we;
  logic [REG_W-1:0] mem_wdata, mem_rdata;
  logic rd_clear;

  // Ready and result state
  logic rdy_n_reg, rdy_n_next;
  logic [REG_W-1:0] data_reg, data_next;
  logic [REG_W-1:0] pend_data_reg, pend_data_next;
  logic pend_reg, pend_next;
  logic [3:0] gap_reg, gap_next;

  // Read address follows the select as it is decoded, so the word is ready at load
  asp_reg_mem asp_reg_mem_inst (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .we_i(mem_we),
    .waddr_i(sel_reg),
    .wdata_i(mem_wdata),
    .raddr_i(sel_next),
    .rdata_o(mem_rdata)
  );

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    in_sh_next = in_sh_reg;
    out_sh_next = out_sh_reg;
    sel_next = sel_reg;
    load_next = 1'b0;
    dout_next = dout_reg;
    clkout_en_next = clkout_en_reg;
    mem_we = 1'b0;
    mem_wdata = {in_sh_reg[REG_W-2:0], din_s};
    rd_clear = 1'b0;
    oe_next = cs_act;
    if (!cs_act) begin
      // Chip select high ends the frame and realigns the port
      st_next = ST_COMM;
      cnt_next = CNT_RST;
      dout_next = 1'b1;
    end else begin
      // Falling-edge updates the output; the word loads once read data settles
      if (load_reg) begin
        unique case (sel_reg)
          SEL_DATA: out_sh_next = data_reg;
          SEL_STATUS: out_sh_next = status_word(rdy_n_reg, align_act);
          default: out_sh_next = mem_rdata;
        endcase
        rd_clear = (sel_reg == SEL_DATA);
      end
      if (st_reg == ST_RD) begin
        if (sclk_fall) begin
          dout_next = out_sh_reg[REG_W-1];
          out_sh_next = {out_sh_reg[REG_W-2:0], 1'b0};
        end
      end else begin
        dout_next = rdy_n_reg;
      end
      // Bits are taken on rising edges only, so clock gaps are harmless
      if (sclk_rise) begin
        in_sh_next = {in_sh_reg[REG_W-2:0], din_s};
        cnt_next = cnt_reg + 5'h01;
        unique case (st_reg)
          ST_COMM: begin
            if (cnt_reg == 5'(CMD_W - 1)) begin
              cnt_next = CNT_RST;
              sel_next = in_sh_reg[CMD_SEL_LSB-1 +: SEL_W];
              if (in_sh_reg[CMD_RD_BIT-1]) begin
                st_next = ST_RD;
                load_next = 1'b1;
              end else begin
                st_next = ST_WR;
              end
            end
          end
          ST_WR: begin
            if (word_end(cnt_reg)) begin
              cnt_next = CNT_RST;
              st_next = ST_COMM;
              mem_we = 1'b1;
              if (sel_reg == SEL_MODE) begin
                clkout_en_next = mem_wdata[MODE_CLKOUT_BIT];
              end
            end
          end
          ST_RD: begin
            // Word count alone closes the frame, so a tied-low select still works
            if (word_end(cnt_reg)) begin
              cnt_next = CNT_RST;
              st_next = ST_COMM;
            end
          end
          default: begin
            cnt_next = CNT_RST;
            st_next = ST_COMM;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_reg <= ST_COMM;
      cnt_reg <= CNT_RST;
      in_sh_reg <= REG_RST;
      out_sh_reg <= REG_RST;
      sel_reg <= SEL_STATUS;
      load_reg <= 1'b0;
      dout_reg <= 1'b1;
      oe_reg <= 1'b0;
      clkout_en_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      in_sh_reg <= in_sh_next;
      out_sh_reg <= out_sh_next;
      sel_reg <= sel_next;
      load_reg <= load_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      clkout_en_reg <= clkout_en_next;
    end
  end

  // Ready handling; the serial state above is independent of alignment
  always_comb begin
    rdy_n_next = rdy_n_reg;
    data_next = data_reg;
    pend_data_next = pend_data_reg;
    pend_next = pend_reg;
    gap_next = gap_reg;
    if (rd_clear) begin
      rdy_n_next = 1'b1;
    end
    // Alignment wins over a new result: the converter is held, nothing stays pending
    if (align_act) begin
      rdy_n_next = 1'b1;
      pend_next = 1'b0;
    end else if (conv_done_i) begin
      if (!rdy_n_reg && !rd_clear) begin
        // Unread result: raise ready, update after a gap
        rdy_n_next = 1'b1;
        pend_next = 1'b1;
        pend_data_next = conv_data_i;
        gap_next = RDY_GAP_CYC;
      end else begin
        data_next = conv_data_i;
        rdy_n_next = 1'b0;
        // A fresh result supersedes any word still waiting out its gap
        pend_next = 1'b0;
      end
    end else if (pend_reg) begin
      if (gap_reg == 4'h1) begin
        data_next = pend_data_reg;
        rdy_n_next = 1'b0;
        pend_next = 1'b0;
      end else begin
        gap_next = gap_reg - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rdy_n_reg <= 1'b1;
      data_reg <= REG_RST;
      pend_data_reg <= REG_RST;
      pend_reg <= 1'b0;
      gap_reg <= 4'h0;
    end else begin
      rdy_n_reg <= rdy_n_next;
      data_reg <= data_next;
      pend_data_reg <= pend_data_next;
      pend_reg <= pend_next;
      gap_reg <= gap_next;
    end
  end

  // Filter, calibration and modulator resets and the internal master clock
  logic align_rst_reg, align_rst_next;
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic mclk_out_reg, mclk_out_next;
  logic mclk_oe_reg, mclk_oe_next;

  // Phase accumulator: average rate set by a truncated increment, each period jitters by one system clock
  always_comb begin
    align_rst_next = align_act;
    acc_next = acc_reg + ACC_INC;
    mclk_out_next = acc_reg[ACC_W-1];
    mclk_oe_next = clkout_en_reg;
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      align_rst_reg <= 1'b0;
      acc_reg <= ACC_RST;
      mclk_out_reg <= 1'b0;
      mclk_oe_reg <= 1'b0;
    end else begin
      align_rst_reg <= align_rst_next;
      acc_reg <= acc_next;
      mclk_out_reg <= mclk_out_next;
      mclk_oe_reg <= mclk_oe_next;
    end
  end

  // Every output is a register; the three resets share one so they always agree
  assign filter_rst_o = align_rst_reg;
  assign cal_rst_o = align_rst_reg;
  assign mod_rst_o = align_rst_reg;
  assign serial_out_done_n_o = dout_reg;
  assign serial_out_done_oe_o = oe_reg;
  assign master_clock_pin_o = mclk_out_reg;
  assign master_clock_pin_oe_o = mclk_oe_reg;

endmodule

// ==== tb/asp_serial_port_properties.sv ====
// Concurrent checks on the serial port block pins
`timescale 1ns/1ns
module asp_serial_port_checker import asp_pkg::*; (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Watched pins
  input wire asp_pins_s host_i,
  input wire logic serial_out_done_oe_o,
  input wire logic filter_align_n_i,
  input wire logic filter_rst_o,
  input wire logic cal_rst_o,
  input wire logic mod_rst_o,
  input wire logic master_clock_pin_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_align_held;
    (!filter_align_n_i) [*7];
  endsequence
  sequence s_align_free;
    filter_align_n_i [*7];
  endsequence
  sequence s_clk_high;
    $rose(master_clock_pin_o) ##[2:3] $fell(master_clock_pin_o);
  endsequence
  sequence s_clk_low;
    $fell(master_clock_pin_o) ##[2:3] $rose(master_clock_pin_o);
  endsequence
  chk_align_hold: assert property (s_align_held |-> filter_rst_o && mod_rst_o)
    else $error("resets low while align held");
  chk_align_free: assert property (s_align_free |-> !filter_rst_o)
    else $error("filter reset high while align free");
  chk_reset_group: assert property (filter_rst_o == cal_rst_o && cal_rst_o == mod_rst_o)
    else $error("reset outputs disagree");
  chk_cs_idle: assert property (host_i.cs_n [*8] |-> !serial_out_done_oe_o)
    else $error("output driven while deselected");
  chk_cs_drive: assert property ((!host_i.cs_n) [*8] |-> serial_out_done_oe_o)
    else $error("output not driven while selected");
  chk_frame_end: assert property ($rose(host_i.cs_n) |-> ##[4:7] !serial_out_done_oe_o)
    else $error("output still driven after frame end");
  chk_clk_high: assert property ($rose(master_clock_pin_o) |-> s_clk_high)
    else $error("clock high time off");
  chk_clk_low: assert property ($fell(master_clock_pin_o) |-> s_clk_low)
    else $error("clock low time off");
endmodule

bind asp_serial_port asp_serial_port_checker asp_serial_port_checker_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_i(host_i),
  .serial_out_done_oe_o(serial_out_done_oe_o), .filter_align_n_i(filter_align_n_i),
  .filter_rst_o(filter_rst_o), .cal_rst_o(cal_rst_o), .mod_rst_o(mod_rst_o),
  .master_clock_pin_o(master_clock_pin_o));

// ==== tb/asp_host_model.sv ====
// Host side serial master driving the converter port
`timescale 1ns/1ns
module asp_host_model import asp_pkg::*; (
  // Clock and data back
  input wire logic mclk_i,
  input wire logic dout_i,
  // Host pins
  output asp_pins_s host_o
);
  // Half a link clock period in system clocks: 320 ns period
  localparam int HALF = 4;
  bit tie_low;
  initial host_o = '{sclk: 1'b1, cs_n: 1'b1, din: 1'b0};
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  task automatic set_tie(input bit t);
    tie_low = t;
    host_o.cs_n = !t;
  endtask
  // Command byte then one register word; optional pause after the command
  task automatic xfer(input logic [CMD_W-1:0] cmd, input logic [REG_W-1:0] wd,
                      input int gap, output logic [REG_W-1:0] rd);
    logic [CMD_W+REG_W-1:0] sh;
    sh = {cmd, wd};
    rd = '0;
    host_o.cs_n = 1'b0;
    tick(HALF);
    for (int i = 0; i < CMD_W + REG_W; i++) begin
      if (i == CMD_W) tick(gap);
      host_o.sclk = 1'b0;
      host_o.din = sh[CMD_W+REG_W-1-i];
      tick(HALF);
      if (i >= CMD_W) rd = {rd[REG_W-2:0], dout_i};
      host_o.sclk = 1'b1;
      tick(HALF);
    end
    host_o.din = ~host_o.din;
    host_o.cs_n = !tie_low;
    // Let the port see the frame end before anything else happens
    tick(2 * HALF);
  endtask
endmodule

// ==== tb/tb_asp_serial_port.sv ====
// Self-checking bench for the converter serial port block
`timescale 1ns/1ns
module tb_asp_serial_port import asp_pkg::*; ;
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic align_n = 1'b1;
  logic conv_done = 1'b0;
  logic [REG_W-1:0] conv_data = '0;
  logic junk = 1'b0;
  asp_pins_s host;
  logic dout, oe, f_rst, c_rst, m_rst, clk_pin, clk_oe, dout_w;
  int n_errors = 0;
  int comparisons = 0;
  always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
  always @(negedge mclk_i) junk <= ~junk;
  // Released output line shows a changing pattern
  assign dout_w = oe ? dout : junk;
  asp_host_model host_inst (.mclk_i(mclk_i), .dout_i(dout_w), .host_o(host));
  asp_serial_port asp_serial_port_inst (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .host_i(host), .serial_out_done_n_o(dout),
    .serial_out_done_oe_o(oe), .filter_align_n_i(align_n), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .filter_rst_o(f_rst), .cal_rst_o(c_rst), .mod_rst_o(m_rst),
    .master_clock_pin_o(clk_pin), .master_clock_pin_oe_o(clk_oe));
  task automatic check(input string what, input logic [REG_W-1:0] seen,
                       input logic [REG_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  function automatic logic [CMD_W-1:0] cmd(input logic rd, input logic [SEL_W-1:0] sel);
    logic [CMD_W-1:0] c;
    c = '0;
    c[CMD_RD_BIT] = rd;
    c[CMD_SEL_LSB +: SEL_W] = sel;
    return c;
  endfunction
  task automatic pulse(input logic [REG_W-1:0] d);
    conv_data = d;
    conv_done = 1'b1;
    tick(1);
    conv_done = 1'b0;
  endtask
  task automatic wait_pin(input logic lvl, input int bound);
    for (int k = 0; k < bound && dout !== lvl; k++) tick(1);
    check("ready pin", {23'h0, dout}, {23'h0, lvl});
  endtask
  task automatic t_regs();
    logic [REG_W-1:0] rd;
    check("clock pin released", {23'h0, clk_oe}, 24'h00_0000);
    host_inst.xfer(cmd(1'b0, SEL_MODE), 24'h00_0001, 0, rd);
    host_inst.xfer(cmd(1'b1, SEL_MODE), 24'h00_0000, 0, rd);
    check("mode word", rd, 24'h00_0001);
    check("clock pin enable", {23'h0, clk_oe}, 24'h00_0001);
    host_inst.xfer(cmd(1'b0, 3'h2), 24'hA5_5A3C, 0, rd);
    host_inst.xfer(cmd(1'b1, 3'h2), 24'h00_0000, 30, rd);
    check("burst word", rd, 24'hA5_5A3C);
    check("deselected enable", {23'h0, oe}, 24'h00_0000);
    $display("test regs done");
  endtask
  task automatic t_ready();
    logic [REG_W-1:0] rd;
    host_inst.set_tie(1'b1);
    tick(8);
    pulse(24'h12_3456);
    wait_pin(1'b0, 10);
    pulse(24'h65_4321);
    tick(2);
    check("ready gap", {23'h0, dout}, 24'h00_0001);
    wait_pin(1'b0, 10);
    host_inst.xfer(cmd(1'b1, SEL_DATA), 24'h00_0000, 0, rd);
    check("result word", rd, 24'h65_4321);
    check("ready cleared", {23'h0, dout}, 24'h00_0001);
    $display("test ready done");
  endtask
  task automatic t_align();
    logic [REG_W-1:0] rd;
    pulse(24'h0F_F0F0);
    wait_pin(1'b0, 10);
    align_n = 1'b0;
    tick(8);
    check("align resets", {21'h0, f_rst, c_rst, m_rst}, 24'h00_0007);
    check("ready forced", {23'h0, dout}, 24'h00_0001);
    pulse(24'h11_1111);
    tick(8);
    check("result ignored", {23'h0, dout}, 24'h00_0001);
    host_inst.xfer(cmd(1'b1, SEL_STATUS), 24'h00_0000, 0, rd);
    check("status word", rd, 24'hC0_0000);
    host_inst.xfer(cmd(1'b1, SEL_MODE), 24'h00_0000, 0, rd);
    check("mode in align", rd, 24'h00_0001);
    align_n = 1'b1;
    tick(8);
    check("resets free", {21'h0, f_rst, c_rst, m_rst}, 24'h00_0000);
    host_inst.set_tie(1'b0);
    tick(8);
    $display("test align done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    tick(2);
    sys_rst_i = 1'b0;
    tick(6);
    t_regs();
    t_ready();
    t_align();
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_errors++;
    finish_test();
  end
endmodule
